// ---- inc/hsas_defs.svh ----
// register offsets, field positions, reset values and timing figures of the heater alarm supervisor
`ifndef HSAS_DEFS_SVH
`define HSAS_DEFS_SVH

// register byte offsets
`define HSAS_REG_CTRL 8'h00
`define HSAS_REG_WARN_TH 8'h04
`define HSAS_REG_CRIT_TH 8'h08
`define HSAS_REG_VOLT_LO 8'h0c
`define HSAS_REG_CURR_LO 8'h10
`define HSAS_REG_RELEASE 8'h14
`define HSAS_REG_STATUS 8'h18
`define HSAS_REG_IRQ_STAT 8'h1c
`define HSAS_REG_IRQ_CLR 8'h20
`define HSAS_REG_IRQ_EN 8'h24

// control register fields
`define HSAS_CTRL_LEVEL 0
`define HSAS_CTRL_POL 1
`define HSAS_CTRL_DSEL 8

// interrupt event bits
`define HSAS_EV_WARN 0
`define HSAS_EV_CRIT 1
`define HSAS_EV_LOST 2
`define HSAS_EV_W 3

// reset values, change rate in 0.1 percent units
`define HSAS_WARN_TH_RST 16'h001e
`define HSAS_CRIT_TH_RST 16'h0032
`define HSAS_VOLT_LO_RST 16'h000a
`define HSAS_CURR_LO_RST 16'h000a

// timing
`define HSAS_CLK_MHZ 125
`define HSAS_BLINK_HALF_MS 500

`endif

// ---- inc/hsas_pkg.sv ----
// types shared by the heater alarm supervisor
package hsas_pkg;

  // supervisory state of one heater channel
  typedef enum logic {
    HSAS_WAIT,
    HSAS_SETTLED
  } hsas_state_t;

  // one channel's measurement results from the measurement logic
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] rate;
    logic pwr_stable;
    logic res_stable;
    logic meas_err;
  } hsas_meas_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hsas_bus_t;

endpackage

// ---- rtl/hsas_top.sv ----
// supervisory state machine and alarm latches of the heater condition monitor
//
// Function
// (RULE1) no voltage and current sensed: light no-signal lamp, show three dashes.
// (RULE2) signal measured: no-signal lamp off, display the reference change rate.
// (RULE3) waiting for stabilization: no deterioration alarm is judged.
// (RULE4) entering stabilized: settled lamp on, start judging alarms.
// (RULE5) stabilized and rate above warning threshold: yellow lamp and fault lamp.
// (RULE6) output level warning-or-critical lets warning drive alarm output too.
// (RULE7) stabilized and rate above critical threshold: red lamp, alarm output on.
// (RULE8) voltage or current below lower limit: back to waiting, no-signal lamp.
// (RULE9) raised alarms stay latched after leaving stabilized.
// (RULE10) before restabilization no new alarm, latched state held.
// (RULE11) latch release returns the status lamp to green.
// (RULE12) rate already over threshold raises alarm in the entering step.
// (RULE13) enter stabilized only when all four conditions hold together.
// (RULE14) leave stabilized when any condition fails or a measurement error occurs.
// (RULE15) status lamp shows most severe level: red over yellow over green.
// (RULE16) fault lamp steady for displayed channel, flashing for others, else dark.
// (RULE17) release is a one-cycle pulse clearing all latches.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hsas_defs.svh"

module hsas_top #(
  parameter int NCH = 2,
  parameter int BLINK_CYC = `HSAS_BLINK_HALF_MS * `HSAS_CLK_MHZ * 1000
) (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire hsas_pkg::hsas_bus_t I_BUS,
  input wire hsas_pkg::hsas_meas_t [NCH-1:0] I_MEAS,
  input wire logic I_RELEASE_N,
  output logic [31:0] O_RDATA,
  output logic O_IRQ,
  output logic O_LAMP_GRN,
  output logic O_LAMP_YEL,
  output logic O_LAMP_RED,
  output logic O_FAULT_LAMP,
  output logic O_SETTLED_LAMP,
  output logic O_NOSIG_LAMP,
  output logic O_DISP_DASH,
  output logic [15:0] O_DISP_RATE,
  output logic O_ALARM_XSTR
);
  import hsas_pkg::*;

  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  // status register packs four bits per channel, so eight channels at most
  generate
    if (NCH < 1 || NCH > 8) begin : g_bad_nch
      $error("NCH must lie between 1 and 8");
    end
    if (BLINK_CYC < 2) begin : g_bad_blink
      $error("BLINK_CYC must be at least 2");
    end
  endgenerate

  // software-visible settings
  logic level_q;
  logic pol_q;
  logic [CW-1:0] dsel_q;
  logic [15:0] warn_th_q;
  logic [15:0] crit_th_q;
  logic [15:0] volt_lo_q;
  logic [15:0] curr_lo_q;
  logic [`HSAS_EV_W-1:0] irq_en_q;
  logic [`HSAS_EV_W-1:0] irq_stat_q;

  // per-channel views
  logic [NCH-1:0] sig_v;
  logic [NCH-1:0] enter_v;
  logic [NCH-1:0] set_v;
  logic [NCH-1:0] warn_v;
  logic [NCH-1:0] crit_v;
  logic [NCH-1:0] wraise_v;
  logic [NCH-1:0] craise_v;
  logic [NCH-1:0] lost_v;

  // release button synchroniser, third stage only for the edge
  logic rel_s1_q;
  logic rel_s2_q;
  logic rel_s3_q;
  logic rel_p;
  logic sw_rel;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      rel_s1_q <= 1'b1;
      rel_s2_q <= 1'b1;
      rel_s3_q <= 1'b1;
    end else begin
      rel_s1_q <= I_RELEASE_N;
      rel_s2_q <= rel_s1_q;
      rel_s3_q <= rel_s2_q;
    end
  end

  // one-cycle release from a register write or a button press
  assign sw_rel = I_BUS.wr && (I_BUS.addr == `HSAS_REG_RELEASE) && I_BUS.wdata[0];
  assign rel_p = sw_rel || (!rel_s2_q && rel_s3_q); // RULE17

  // register writes
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      level_q <= 1'b0;
      pol_q <= 1'b0;
      dsel_q <= '0;
      warn_th_q <= `HSAS_WARN_TH_RST;
      crit_th_q <= `HSAS_CRIT_TH_RST;
      volt_lo_q <= `HSAS_VOLT_LO_RST;
      curr_lo_q <= `HSAS_CURR_LO_RST;
      irq_en_q <= '0;
    end else if (I_BUS.wr) begin
      case (I_BUS.addr)
        `HSAS_REG_CTRL: begin
          level_q <= I_BUS.wdata[`HSAS_CTRL_LEVEL];
          pol_q <= I_BUS.wdata[`HSAS_CTRL_POL];
          dsel_q <= I_BUS.wdata[`HSAS_CTRL_DSEL +: CW];
        end
        `HSAS_REG_WARN_TH: warn_th_q <= I_BUS.wdata[15:0];
        `HSAS_REG_CRIT_TH: crit_th_q <= I_BUS.wdata[15:0];
        `HSAS_REG_VOLT_LO: volt_lo_q <= I_BUS.wdata[15:0];
        `HSAS_REG_CURR_LO: curr_lo_q <= I_BUS.wdata[15:0];
        `HSAS_REG_IRQ_EN: irq_en_q <= I_BUS.wdata[`HSAS_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // per-channel supervisor
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      hsas_state_t state_q;
      logic warn_q;
      logic crit_q;

      assign sig_v[c] = (I_MEAS[c].volt >= volt_lo_q) && (I_MEAS[c].curr >= curr_lo_q); // RULE8
      // all four conditions together, and no measurement error
      assign enter_v[c] = I_MEAS[c].pwr_stable && I_MEAS[c].res_stable && sig_v[c]
                          && !I_MEAS[c].meas_err; // RULE13 RULE14
      // judging follows the next state, so the entering step already judges
      assign wraise_v[c] = enter_v[c] && (I_MEAS[c].rate > warn_th_q); // RULE3 RULE5 RULE12
      assign craise_v[c] = enter_v[c] && (I_MEAS[c].rate > crit_th_q); // RULE7 RULE10
      assign lost_v[c] = (state_q == HSAS_SETTLED) && !enter_v[c];
      assign set_v[c] = (state_q == HSAS_SETTLED);
      assign warn_v[c] = warn_q;
      assign crit_v[c] = crit_q;

      // two-state supervisor
      always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
          state_q <= HSAS_WAIT;
        end else begin
          case (state_q)
            HSAS_WAIT: if (enter_v[c]) state_q <= HSAS_SETTLED; // RULE4 RULE13
            HSAS_SETTLED: if (!enter_v[c]) state_q <= HSAS_WAIT; // RULE8 RULE14
            default: state_q <= HSAS_WAIT;
          endcase
        end
      end

      // latches hold across leaving; release wins so a cleared flag is judged afresh
      always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
          warn_q <= 1'b0;
          crit_q <= 1'b0;
        end else if (rel_p) begin
          warn_q <= 1'b0; // RULE11 RULE17
          crit_q <= 1'b0;
        end else begin
          warn_q <= warn_q || wraise_v[c]; // RULE9
          crit_q <= crit_q || craise_v[c]; // RULE9 RULE10
        end
      end
    end
  endgenerate

  // displayed channel, out-of-range selection falls back to channel 0
  logic [CW-1:0] dch;
  logic any_warn;
  logic any_crit;
  logic any_alarm;
  logic disp_alarm;
  logic alarm_act;
  assign dch = (int'(dsel_q) < NCH) ? dsel_q : '0;
  assign any_warn = |warn_v;
  assign any_crit = |crit_v;
  assign any_alarm = any_warn || any_crit;
  assign disp_alarm = warn_v[dch] || crit_v[dch];
  assign alarm_act = any_crit || (level_q && any_warn); // RULE6 RULE7

  // fault lamp blink timer; free running so all flashing lamps stay in phase
  logic [31:0] blink_cnt_q;
  logic blink_q;
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == 32'(BLINK_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // lamps, display and transistor, all registered
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_LAMP_GRN <= 1'b1;
      O_LAMP_YEL <= 1'b0;
      O_LAMP_RED <= 1'b0;
      O_FAULT_LAMP <= 1'b0;
      O_SETTLED_LAMP <= 1'b0;
      O_NOSIG_LAMP <= 1'b1;
      O_DISP_DASH <= 1'b1;
      O_DISP_RATE <= 16'h0000;
      O_ALARM_XSTR <= 1'b1;
    end else begin
      O_LAMP_RED <= any_crit; // RULE7 RULE15
      O_LAMP_YEL <= !any_crit && any_warn; // RULE5 RULE15
      O_LAMP_GRN <= !any_alarm; // RULE11 RULE15
      O_FAULT_LAMP <= disp_alarm || (any_alarm && blink_q); // RULE5 RULE16
      O_SETTLED_LAMP <= set_v[dch]; // RULE4 RULE8
      O_NOSIG_LAMP <= !sig_v[dch]; // RULE1 RULE2 RULE8
      O_DISP_DASH <= !sig_v[dch]; // RULE1
      O_DISP_RATE <= sig_v[dch] ? I_MEAS[dch].rate : 16'h0000; // RULE2
      // normally closed conducts while quiet, normally open conducts in alarm
      O_ALARM_XSTR <= pol_q ? alarm_act : !alarm_act; // RULE6 RULE7
    end
  end

  // interrupt events: a new raise on any channel or any channel leaving stabilized
  logic [`HSAS_EV_W-1:0] ev;
  logic [`HSAS_EV_W-1:0] irq_clr;
  assign ev[`HSAS_EV_WARN] = |(wraise_v & ~warn_v);
  assign ev[`HSAS_EV_CRIT] = |(craise_v & ~crit_v);
  assign ev[`HSAS_EV_LOST] = |lost_v;
  assign irq_clr = (I_BUS.wr && I_BUS.addr == `HSAS_REG_IRQ_CLR) ? I_BUS.wdata[`HSAS_EV_W-1:0] : '0;

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      irq_stat_q <= '0;
      O_IRQ <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
      O_IRQ <= |(irq_stat_q & irq_en_q);
    end
  end

  // channel status word: {crit, warn, settled, signal} per channel
  logic [31:0] status_w;
  always_comb begin
    status_w = '0;
    for (int i = 0; i < NCH; i++) begin
      status_w[4*i +: 4] = {crit_v[i], warn_v[i], set_v[i], sig_v[i]};
    end
  end

  // read data stands for the one cycle after the strobe, else zero
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_RDATA <= '0;
    end else if (I_BUS.rd) begin
      case (I_BUS.addr)
        `HSAS_REG_CTRL: O_RDATA <= {16'h0000, 8'(dsel_q), 6'h00, pol_q, level_q};
        `HSAS_REG_WARN_TH: O_RDATA <= {16'h0000, warn_th_q};
        `HSAS_REG_CRIT_TH: O_RDATA <= {16'h0000, crit_th_q};
        `HSAS_REG_VOLT_LO: O_RDATA <= {16'h0000, volt_lo_q};
        `HSAS_REG_CURR_LO: O_RDATA <= {16'h0000, curr_lo_q};
        `HSAS_REG_STATUS: O_RDATA <= status_w;
        `HSAS_REG_IRQ_STAT: O_RDATA <= {29'h0000_0000, irq_stat_q};
        `HSAS_REG_IRQ_EN: O_RDATA <= {29'h0000_0000, irq_en_q};
        default: O_RDATA <= '0;
      endcase
    end else begin
      O_RDATA <= '0;
    end
  end

  // checks on channel 0, on the displayed channel and on the combined lamps
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);

  no_signal_dash_a: assert property (!sig_v[dch] |=> O_DISP_DASH && O_NOSIG_LAMP) // RULE1
    else $error("no signal without dashes");
  signal_rate_a: assert property (sig_v[dch] |=> !O_NOSIG_LAMP && O_DISP_RATE == $past(I_MEAS[dch].rate)) // RULE2
    else $error("rate not displayed");
  wait_no_judge_a: assert property (!enter_v[0] && !rel_p |=> $stable({warn_v[0], crit_v[0]})) // RULE3 RULE10
    else $error("alarm judged while waiting");
  enter_settled_a: assert property (enter_v[0] |=> set_v[0]) // RULE4 RULE13
    else $error("did not settle");
  // the fault lamp shows the select and blink phase of the cycle before, so compare against those
  warn_raise_a: assert property (enter_v[0] && I_MEAS[0].rate > warn_th_q && !rel_p |=> // RULE5 RULE12
    warn_v[0] ##1 (O_LAMP_YEL || O_LAMP_RED) && (O_FAULT_LAMP || ($past(dch) != '0 && !$past(blink_q))))
    else $error("warning not shown");
  out_level_a: assert property (!pol_q && level_q && any_warn |=> !O_ALARM_XSTR) // RULE6
    else $error("warning did not drive output");
  crit_out_a: assert property (!pol_q && any_crit |=> !O_ALARM_XSTR && O_LAMP_RED) // RULE7
    else $error("critical not shown");
  leave_wait_a: assert property (set_v[0] && !sig_v[0] |=> !set_v[0]) // RULE8 RULE14
    else $error("stayed settled");
  alarm_latch_a: assert property (crit_v[0] && !rel_p |=> crit_v[0]) // RULE9
    else $error("latch dropped");
  release_clr_a: assert property (rel_p |=> warn_v == '0 && crit_v == '0) // RULE11 RULE17
    else $error("release did not clear");
  lamp_prio_a: assert property (any_crit |=> O_LAMP_RED && !O_LAMP_YEL && !O_LAMP_GRN) // RULE15
    else $error("red not prioritised");
  fault_dark_a: assert property (!any_alarm |=> !O_FAULT_LAMP) // RULE16
    else $error("fault lamp without alarm");

  // output polarity, lamp colours, flashing and settling
  warn_quiet_a: assert property (!pol_q && !level_q && !any_crit |=> O_ALARM_XSTR) // RULE6
    else $error("warning drove output at critical-only level");
  pol_open_a: assert property (pol_q && any_crit |=> O_ALARM_XSTR) // RULE7
    else $error("normally open output not conducting in alarm");
  crit_raise_a: assert property (enter_v[0] && I_MEAS[0].rate > crit_th_q && !rel_p |=> crit_v[0]) // RULE7 RULE12
    else $error("critical not latched");
  yellow_only_a: assert property (!any_crit && any_warn |=> O_LAMP_YEL && !O_LAMP_RED && !O_LAMP_GRN) // RULE5 RULE15
    else $error("yellow not shown");
  green_clear_a: assert property (!any_alarm |=> O_LAMP_GRN && !O_LAMP_YEL && !O_LAMP_RED) // RULE11 RULE15
    else $error("green not shown");
  fault_steady_a: assert property (disp_alarm |=> O_FAULT_LAMP) // RULE16
    else $error("fault lamp not steady");
  fault_flash_a: assert property (any_alarm && !disp_alarm |=> O_FAULT_LAMP == $past(blink_q)) // RULE16
    else $error("fault lamp not flashing");
  settled_lamp_a: assert property (set_v[dch] |=> O_SETTLED_LAMP) // RULE4
    else $error("settled lamp dark");
  no_enter_a: assert property (!enter_v[0] |=> !set_v[0]) // RULE13 RULE14
    else $error("settled without all conditions");
  lost_sticky_a: assert property (ev[`HSAS_EV_LOST] |=> irq_stat_q[`HSAS_EV_LOST]) // RULE14
    else $error("leave event not recorded");

  settle_c: cover property (!set_v[0] ##1 set_v[0]);
  crit_c: cover property (craise_v[0] ##1 crit_v[0]);
  latch_leave_c: cover property (crit_v[0] && set_v[0] ##1 !set_v[0] && crit_v[0]);
  release_c: cover property (any_alarm ##1 rel_p ##1 O_LAMP_GRN);
  flash_c: cover property (any_alarm && !disp_alarm ##1 O_FAULT_LAMP ##1 !O_FAULT_LAMP);

endmodule
`default_nettype wire

// ---- test/hsas_heater_model.sv ----
// behavioural heater supply as seen through the voltage and current sensing
`timescale 1ns/1ps
`default_nettype none

module hsas_heater_model (
  input wire logic i_clk,
  input wire logic i_on,
  input wire logic i_stable,
  input wire logic [15:0] i_rate,
  input wire logic i_err,
  output var hsas_pkg::hsas_meas_t o_meas
);
  import hsas_pkg::*;
  // one new measurement per cycle; a heater that is off reads zero voltage and current, never its last value
  always_ff @(posedge i_clk) begin
    o_meas.volt <= i_on ? 16'h00dc : 16'h0000;
    o_meas.curr <= i_on ? 16'h0019 : 16'h0000;
    o_meas.rate <= i_rate;
    o_meas.pwr_stable <= i_on & i_stable;
    o_meas.res_stable <= i_on & i_stable;
    o_meas.meas_err <= i_err;
  end
endmodule

`default_nettype wire

// ---- test/hsas_top_tb_top.sv ----
// self-checking bench for the heater alarm supervisor
`timescale 1ns/1ps
`default_nettype none
`include "hsas_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end

module hsas_top_tb_top;
  import hsas_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rel_n = 1'b1;
  hsas_bus_t bus = '0;
  wire hsas_meas_t [1:0] meas;
  logic [1:0] on_v = '0;
  logic [1:0] stb_v = '0;
  logic [1:0] err_v = '0;
  logic [1:0][15:0] rate_v = '0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic grn, yel, red, flt, stl, nosig, dash, xstr, irq;
  logic [15:0] rate_o;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int n;

  // 125 MHz
  always #4 clk = ~clk;

  // short blink so the flashing fault lamp shows within a few cycles
  hsas_top #(.NCH(2), .BLINK_CYC(4)) hsas_top_i (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_BUS(bus), .I_MEAS(meas), .I_RELEASE_N(rel_n),
    .O_RDATA(rdata), .O_IRQ(irq), .O_LAMP_GRN(grn), .O_LAMP_YEL(yel), .O_LAMP_RED(red),
    .O_FAULT_LAMP(flt), .O_SETTLED_LAMP(stl), .O_NOSIG_LAMP(nosig), .O_DISP_DASH(dash),
    .O_DISP_RATE(rate_o), .O_ALARM_XSTR(xstr));

  // one heater per channel
  for (genvar c = 0; c < 2; c++) begin : g_ch
    hsas_heater_model hsas_heater_model_i (.i_clk(clk), .i_on(on_v[c]), .i_stable(stb_v[c]),
      .i_rate(rate_v[c]), .i_err(err_v[c]), .o_meas(meas[c]));
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic hold(input int c, input logic o, input logic s, input logic [15:0] r, input logic e);
    @(posedge clk);
    on_v[c] <= o;
    stb_v[c] <= s;
    rate_v[c] <= r;
    err_v[c] <= e;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic done(input string s);
    $display("test %0s done", s);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({grn, yel, red, nosig, dash, xstr, stl}, 7'b1001110)
    rd(`HSAS_REG_WARN_TH);
    `CHK(d, 32'h0000001e)
    rd(`HSAS_REG_CRIT_TH);
    `CHK(d, 32'h00000032)
    rd(8'h30);
    `CHK(d, 32'h00000000)
    wr(`HSAS_REG_IRQ_EN, 32'h7);
    done("reset");
    // heater on but still warming: display live, no judging yet
    hold(0, 1'b1, 1'b0, 16'd60, 1'b0);
    step(4);
    `CHK({nosig, dash, rate_o}, {2'b00, 16'd60})
    `CHK({grn, yel, red, stl}, 4'b1000)
    // raise the voltage limit above the heater: signal counts as lost
    wr(`HSAS_REG_VOLT_LO, 32'h100);
    rd(`HSAS_REG_VOLT_LO);
    `CHK({d, nosig}, {32'h00000100, 1'b1})
    wr(`HSAS_REG_VOLT_LO, 32'h0a);
    done("warmup");
    hold(0, 1'b1, 1'b1, 16'd20, 1'b0);
    step(4);
    `CHK({grn, stl}, 2'b11)
    hold(0, 1'b1, 1'b1, 16'd40, 1'b0);
    step(4);
    `CHK({grn, yel, red, flt}, 4'b0101)
    `CHK({xstr, irq}, 2'b11)
    rd(`HSAS_REG_IRQ_STAT);
    `CHK(d, 32'h00000001)
    rd(`HSAS_REG_STATUS);
    `CHK(d[3:0], 4'h7)
    wr(`HSAS_REG_STATUS, 32'h0);
    rd(`HSAS_REG_STATUS);
    `CHK(d[3:0], 4'h7)
    wr(`HSAS_REG_CTRL, 32'h1);
    step(3);
    `CHK(xstr, 1'b0)
    wr(`HSAS_REG_CTRL, 32'h0);
    wr(`HSAS_REG_IRQ_CLR, 32'h7);
    step(3);
    `CHK({xstr, irq}, 2'b10)
    done("warning");
    hold(0, 1'b1, 1'b1, 16'd60, 1'b0);
    step(4);
    `CHK({grn, yel, red, xstr}, 4'b0010)
    // normally open polarity conducts while the alarm is active
    wr(`HSAS_REG_CTRL, 32'h2);
    rd(`HSAS_REG_CTRL);
    `CHK({d, xstr}, {32'h00000002, 1'b1})
    wr(`HSAS_REG_CTRL, 32'h0);
    wr(`HSAS_REG_IRQ_EN, 32'h0);
    // heater stops: alarms must survive the drop out of settled
    hold(0, 1'b0, 1'b0, 16'd60, 1'b0);
    step(4);
    `CHK({stl, nosig}, 2'b01)
    `CHK({red, flt, xstr, irq}, 4'b1100)
    rd(`HSAS_REG_IRQ_STAT);
    `CHK(d & 32'h4, 32'h4)
    hold(0, 1'b1, 1'b0, 16'd60, 1'b0);
    step(4);
    `CHK({grn, yel, red, nosig}, 4'b0010)
    wr(`HSAS_REG_RELEASE, 32'h1);
    step(3);
    `CHK({grn, yel, red, xstr, flt}, 5'b10010)
    step(4);
    `CHK(grn, 1'b1)
    done("latch");
    // rate already past warning when settling: alarm in the same step
    hold(0, 1'b1, 1'b1, 16'd40, 1'b0);
    n = 0;
    while (stl !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    `CHK({stl, yel}, 2'b11)
    hold(0, 1'b1, 1'b1, 16'd40, 1'b1);
    step(4);
    `CHK(stl, 1'b0)
    hold(0, 1'b1, 1'b1, 16'd40, 1'b0);
    step(4);
    `CHK(stl, 1'b1)
    hold(0, 1'b1, 1'b0, 16'd40, 1'b0);
    step(4);
    `CHK(stl, 1'b0)
    done("resettle");
    // release through the button pin
    @(posedge clk);
    rel_n <= 1'b0;
    repeat (8) @(posedge clk);
    rel_n <= 1'b1;
    #1;
    `CHK({grn, yel, red}, 3'b100)
    hold(1, 1'b1, 1'b1, 16'd60, 1'b0);
    step(4);
    `CHK({grn, yel, red}, 3'b001)
    n = 0;
    for (int i = 0; i < 16; i++) begin
      step(1);
      n += int'(flt === 1'b1);
    end
    `CHK(n > 0 && n < 16, 1'b1)
    wr(`HSAS_REG_CTRL, 32'h100);
    step(2);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      step(1);
      n += int'(flt === 1'b1);
    end
    `CHK(n == 16, 1'b1)
    wr(`HSAS_REG_CTRL, 32'h0);
    hold(0, 1'b1, 1'b1, 16'd40, 1'b0);
    step(4);
    `CHK({grn, yel, red, flt}, 4'b0011)
    done("channels");
    close_out();
  end
endmodule

`default_nettype wire
